// ---- verilog/qrs_top.v ----
// serial flash command sequencer: quad reads, burst wrap, erases
// Functional notes
// - quad reads need quad enable set
// - quad output read: opcode, address, eight dummies
// - sample on rising, shift on falling edge
// - address increments per byte, wraps to zero
// - chip select high ends read, idle
// - busy device rejects quad reads harmlessly
// - quad io read: quad address, mode, dummies
// - mode select 10 skips next opcode
// - other mode select restores opcode next time
// - wrap command: opcode, 24 dummies, config
// - wrap in aligned 8/16/32/64 section
// - wrap setting persists, default disabled
// - erase requires write enable latch set
// - page erase clears addressed 256 bytes
// - sector chosen by upper bits to 12
// - erase discarded unless select rises on boundary
// - cycle starts at select rise, clears latch
// - protected region is not erased
// - protected half block still clears latch
// - block erase accepts any inner address
// - erase sequences use only line zero
`timescale 1ns/1ps
`default_nettype none
`include "qrs_defs.vh"
module qrs_top #(
  parameter [31:0] PE_CYC = `QRS_PE_TIME_US * `QRS_MCLK_MHZ,
  parameter [31:0] SE_CYC = `QRS_SE_TIME_US * `QRS_MCLK_MHZ,
  parameter [31:0] HBE_CYC = `QRS_HBE_TIME_US * `QRS_MCLK_MHZ,
  parameter [31:0] BE_CYC = `QRS_BE_TIME_US * `QRS_MCLK_MHZ
) (
  input wire MCLK,
  input wire RST_B,
  input wire CS_B,
  input wire SCLK,
  input wire [3:0] IO_LINE_IN,
  output reg [3:0] IO_LINE_OUT,
  output reg [3:0] IO_LINE_OE,
  input wire QUAD_ENABLE_BIT,
  input wire [4:0] BLOCK_PROTECT_BITS,
  input wire EXT_BUSY,
  output reg [23:0] MEM_ADDR,
  input wire [7:0] MEM_RDATA,
  output reg ERASE_GO,
  output reg [23:0] ERASE_BASE,
  output reg [1:0] ERASE_SIZE,
  output reg WRITE_IN_PROGRESS,
  output reg WRITE_ENABLE_LATCH,
  output reg CONTINUOUS_READ_ACTIVE
);
  // ------------------------------------------------------------------
  // states
  // ------------------------------------------------------------------
  localparam [7:0] ST_IDLE = 8'h01;
  localparam [7:0] ST_CMD = 8'h02;
  localparam [7:0] ST_ADDR = 8'h04;
  localparam [7:0] ST_MODE = 8'h08;
  localparam [7:0] ST_DUMMY = 8'h10;
  localparam [7:0] ST_DATA = 8'h20;
  localparam [7:0] ST_WCFG = 8'h40;
  localparam [7:0] ST_END = 8'h80;

  // ------------------------------------------------------------------
  // reset release and pin synchronisers
  // ------------------------------------------------------------------
  reg rst_meta_q;
  reg rst_n_q;
  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  wire [5:0] pins_s;
  qrs_sync #(.W(6)) u_sync (
    .clk(MCLK),
    .rst_n(rst_n_q),
    .d({CS_B, SCLK, IO_LINE_IN}),
    .q(pins_s)
  );
  wire cs_b_s = pins_s[5];
  wire sclk_s = pins_s[4];
  wire [3:0] io_s = pins_s[3:0];

  reg cs_b_d1_q;
  reg sclk_d1_q;
  wire sclk_rise = sclk_s & ~sclk_d1_q;
  wire sclk_fall = ~sclk_s & sclk_d1_q;
  wire cs_fall = ~cs_b_s & cs_b_d1_q;
  wire cs_rise = cs_b_s & ~cs_b_d1_q;

  // ------------------------------------------------------------------
  // sequencer registers
  // ------------------------------------------------------------------
  reg [7:0] st_q;
  reg [4:0] cnt_q;
  reg [7:0] cmd_q;
  reg [23:0] addr_q;
  reg [7:0] mode_q;
  reg got_mode_q;
  reg [7:0] wcfg_q;
  reg nib_q;
  reg [3:0] low_nib_q;
  reg wrap_dis_q;
  reg [1:0] wrap_len_q;
  reg tmr_load_q;
  reg [31:0] tmr_cnt_q;
  wire tmr_done;

  qrs_tmr #(.W(32)) u_tmr (
    .clk(MCLK),
    .rst_n(rst_n_q),
    .load(tmr_load_q),
    .count(tmr_cnt_q),
    .done(tmr_done)
  );

  wire busy = WRITE_IN_PROGRESS | EXT_BUSY;
  wire [4:0] cnt_nx = cnt_q + 5'h01;
  wire [7:0] cmd_sh = {cmd_q[6:0], io_s[0]};
  wire quad_addr = (cmd_q == `QRS_OP_QIO);

  // ------------------------------------------------------------------
  // read address stepping
  // ------------------------------------------------------------------
  wire [23:0] inc = addr_q + 24'h000001;
  wire [23:0] wmask = (`QRS_WRAP_BASE << wrap_len_q) - 24'h000001;
  wire use_wrap = quad_addr & ~wrap_dis_q;
  // a wrapped burst stays inside its aligned section of the page
  wire [23:0] addr_step = use_wrap ? ((addr_q & ~wmask) | (inc & wmask))
                                   : (inc & `QRS_ADDR_MASK);

  // ------------------------------------------------------------------
  // erase region and protection
  // ------------------------------------------------------------------
  reg [1:0] er_size;
  reg [23:0] er_span;
  reg [31:0] er_cyc;
  reg er_cmd;
  always @* begin
    er_cmd = 1'b1;
    case (cmd_q)
      `QRS_OP_PE: begin
        er_size = `QRS_SZ_PAGE;
        er_span = `QRS_SPAN_PAGE;
        er_cyc = PE_CYC;
      end
      `QRS_OP_SE: begin
        er_size = `QRS_SZ_SECT;
        er_span = `QRS_SPAN_SECT;
        er_cyc = SE_CYC;
      end
      `QRS_OP_HBE: begin
        er_size = `QRS_SZ_HBLK;
        er_span = `QRS_SPAN_HBLK;
        er_cyc = HBE_CYC;
      end
      `QRS_OP_BE: begin
        er_size = `QRS_SZ_BLK;
        er_span = `QRS_SPAN_BLK;
        er_cyc = BE_CYC;
      end
      default: begin
        er_cmd = 1'b0;
        er_size = `QRS_SZ_PAGE;
        er_span = `QRS_SPAN_PAGE;
        er_cyc = PE_CYC;
      end
    endcase
  end

  // low address bits inside the region are don't care
  wire [23:0] er_base = addr_q & `QRS_ADDR_MASK & ~er_span;
  wire [24:0] er_end = {1'b0, er_base | er_span};
  wire [23:0] prot_unit = BLOCK_PROTECT_BITS[4] ? `QRS_PROT_UNIT_SM
                                                 : `QRS_PROT_UNIT_LG;
  wire [24:0] prot_len = {1'b0, prot_unit} << BLOCK_PROTECT_BITS[2:0];
  wire prot_full = prot_len >= `QRS_ARRAY_TOP;
  wire prot_hit_top = er_end >= (`QRS_ARRAY_TOP - prot_len);
  wire prot_hit_bot = {1'b0, er_base} < prot_len;
  // protection grows from the top, or from the bottom when bit3 is set
  wire protected_rgn = (BLOCK_PROTECT_BITS[2:0] != 3'h0) &
                       (prot_full | (BLOCK_PROTECT_BITS[3] ? prot_hit_bot : prot_hit_top));

  // ------------------------------------------------------------------
  // main sequencer
  // ------------------------------------------------------------------
  always @(posedge MCLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cs_b_d1_q <= 1'b1;
      // matches the synchroniser's reset level, so no false rising edge follows reset
      sclk_d1_q <= 1'b1;
      st_q <= ST_IDLE;
      cnt_q <= 5'h00;
      cmd_q <= 8'h00;
      addr_q <= 24'h000000;
      mode_q <= 8'h00;
      got_mode_q <= 1'b0;
      wcfg_q <= 8'h00;
      nib_q <= 1'b0;
      low_nib_q <= 4'h0;
      wrap_dis_q <= `QRS_WRAP_DIS_RST;
      wrap_len_q <= `QRS_WRAP_LEN_RST;
      tmr_load_q <= 1'b0;
      tmr_cnt_q <= 32'h00000000;
      IO_LINE_OUT <= 4'h0;
      IO_LINE_OE <= 4'h0;
      MEM_ADDR <= 24'h000000;
      ERASE_GO <= 1'b0;
      ERASE_BASE <= 24'h000000;
      ERASE_SIZE <= `QRS_SZ_PAGE;
      WRITE_IN_PROGRESS <= 1'b0;
      WRITE_ENABLE_LATCH <= 1'b0;
      CONTINUOUS_READ_ACTIVE <= 1'b0;
    end else begin
      cs_b_d1_q <= cs_b_s;
      sclk_d1_q <= sclk_s;
      // address bits above the array are don't care, the array aliases
      MEM_ADDR <= addr_q & `QRS_ADDR_MASK;
      ERASE_GO <= 1'b0;
      tmr_load_q <= 1'b0;
      if (tmr_done) begin
        WRITE_IN_PROGRESS <= 1'b0;
        WRITE_ENABLE_LATCH <= 1'b0;
      end
      if (cs_rise) begin
        // releasing the lines first avoids contention with the next command
        st_q <= ST_IDLE;
        IO_LINE_OE <= 4'h0;
        got_mode_q <= 1'b0;
        CONTINUOUS_READ_ACTIVE <= got_mode_q &
                                  (mode_q[5:4] == `QRS_CONT_SEL);
        if (st_q == ST_END) begin
          if (cmd_q == `QRS_OP_WRITE_ENABLE_COMMAND && !busy)
            WRITE_ENABLE_LATCH <= 1'b1;
          if (cmd_q == `QRS_OP_WRAP) begin
            wrap_dis_q <= wcfg_q[`QRS_WRAP_DIS_BIT];
            wrap_len_q <= wcfg_q[`QRS_WRAP_LEN_HI:`QRS_WRAP_LEN_LO];
          end
          if (er_cmd && WRITE_ENABLE_LATCH && !busy) begin
            WRITE_IN_PROGRESS <= 1'b1;
            tmr_load_q <= 1'b1;
            tmr_cnt_q <= er_cyc;
            ERASE_BASE <= er_base;
            ERASE_SIZE <= er_size;
            ERASE_GO <= ~protected_rgn;
          end
        end
      end else if (cs_fall) begin
        cnt_q <= 5'h00;
        IO_LINE_OE <= 4'h0;
        if (CONTINUOUS_READ_ACTIVE && QUAD_ENABLE_BIT && !busy) begin
          cmd_q <= `QRS_OP_QIO;
          st_q <= ST_ADDR;
        end else begin
          cmd_q <= 8'h00;
          st_q <= ST_CMD;
        end
      end else if (!cs_b_s && sclk_rise) begin
        // all command, address and mode bits enter here
        cnt_q <= cnt_nx;
        case (st_q)
          ST_CMD: begin
            cmd_q <= cmd_sh;
            if (cnt_nx == `QRS_CMD_CLKS) begin
              cnt_q <= 5'h00;
              case (cmd_sh)
                `QRS_OP_QOUT, `QRS_OP_QIO:
                  // a refused read leaves the running cycle untouched
                  st_q <= (QUAD_ENABLE_BIT && !busy) ? ST_ADDR : ST_IDLE;
                `QRS_OP_WRAP, `QRS_OP_PE, `QRS_OP_SE, `QRS_OP_HBE, `QRS_OP_BE:
                  st_q <= ST_ADDR;
                `QRS_OP_WRITE_ENABLE_COMMAND:
                  st_q <= ST_END;
                `QRS_OP_CRR: begin
                  CONTINUOUS_READ_ACTIVE <= 1'b0;
                  st_q <= ST_IDLE;
                end
                default:
                  st_q <= ST_IDLE;
              endcase
            end
          end
          ST_ADDR: begin
            if (quad_addr)
              addr_q <= {addr_q[19:0], io_s};
            else
              addr_q <= {addr_q[22:0], io_s[0]};
            if (cnt_nx == (quad_addr ? `QRS_ADDR4_CLKS : `QRS_ADDR1_CLKS)) begin
              cnt_q <= 5'h00;
              if (quad_addr)
                st_q <= ST_MODE;
              else if (cmd_q == `QRS_OP_QOUT)
                st_q <= ST_DUMMY;
              else if (cmd_q == `QRS_OP_WRAP)
                st_q <= ST_WCFG;
              else
                st_q <= ST_END;
            end
          end
          ST_MODE: begin
            mode_q <= {mode_q[3:0], io_s};
            if (cnt_nx == `QRS_MODE_CLKS) begin
              cnt_q <= 5'h00;
              got_mode_q <= 1'b1;
              st_q <= ST_DUMMY;
            end
          end
          ST_DUMMY: begin
            if (cnt_nx == (quad_addr ? `QRS_QIO_DUMMY : `QRS_QOUT_DUMMY)) begin
              cnt_q <= 5'h00;
              nib_q <= 1'b0;
              st_q <= ST_DATA;
            end
          end
          ST_WCFG: begin
            wcfg_q <= {wcfg_q[6:0], io_s[0]};
            if (cnt_nx == `QRS_WCFG_CLKS) begin
              cnt_q <= 5'h00;
              st_q <= ST_END;
            end
          end
          ST_END:
            // any clock past the boundary discards the command
            st_q <= ST_IDLE;
          default:
            cnt_q <= 5'h00;
        endcase
      end else if (!cs_b_s && sclk_fall && st_q == ST_DATA) begin
        // the byte for addr_q has settled on MEM_RDATA since the last edge
        IO_LINE_OE <= 4'hF;
        if (!nib_q) begin
          IO_LINE_OUT <= MEM_RDATA[7:4];
          low_nib_q <= MEM_RDATA[3:0];
          nib_q <= 1'b1;
        end else begin
          IO_LINE_OUT <= low_nib_q;
          nib_q <= 1'b0;
          addr_q <= addr_step;
        end
      end
    end
  end
endmodule // qrs_top
`default_nettype wire

// ---- verilog/qrs_defs.vh ----
// constants of the quad read and erase sequencer
`ifndef QRS_DEFS_VH
`define QRS_DEFS_VH
// ------------------------------------------------------------------
// opcodes
// ------------------------------------------------------------------
`define QRS_OP_WRITE_ENABLE_COMMAND 8'h06
`define QRS_OP_QOUT 8'h6B
`define QRS_OP_QIO 8'hEB
`define QRS_OP_WRAP 8'h77
`define QRS_OP_PE 8'h81
`define QRS_OP_SE 8'h20
`define QRS_OP_HBE 8'h52
`define QRS_OP_BE 8'hD8
`define QRS_OP_CRR 8'hFF
// ------------------------------------------------------------------
// phase lengths in serial clocks
// ------------------------------------------------------------------
`define QRS_CMD_CLKS 5'h08
`define QRS_ADDR1_CLKS 5'h18
`define QRS_ADDR4_CLKS 5'h06
`define QRS_MODE_CLKS 5'h02
`define QRS_QIO_DUMMY 5'h04
`define QRS_QOUT_DUMMY 5'h08
`define QRS_WCFG_CLKS 5'h08
// ------------------------------------------------------------------
// array, fields and reset values
// ------------------------------------------------------------------
`define QRS_ADDR_MASK 24'h03FFFF
`define QRS_ARRAY_TOP 25'h0040000
`define QRS_CONT_SEL 2'h2
`define QRS_WRAP_DIS_BIT 4
`define QRS_WRAP_LEN_HI 6
`define QRS_WRAP_LEN_LO 5
`define QRS_WRAP_DIS_RST 1'h1
`define QRS_WRAP_LEN_RST 2'h0
`define QRS_WRAP_BASE 24'h000008
`define QRS_PROT_UNIT_LG 24'h010000
`define QRS_PROT_UNIT_SM 24'h001000
// ------------------------------------------------------------------
// erase sizes: code and span minus one
// ------------------------------------------------------------------
`define QRS_SZ_PAGE 2'h0
`define QRS_SZ_SECT 2'h1
`define QRS_SZ_HBLK 2'h2
`define QRS_SZ_BLK 2'h3
`define QRS_SPAN_PAGE 24'h0000FF
`define QRS_SPAN_SECT 24'h000FFF
`define QRS_SPAN_HBLK 24'h007FFF
`define QRS_SPAN_BLK 24'h00FFFF
// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define QRS_MCLK_MHZ 200
`define QRS_PE_TIME_US 10000
`define QRS_SE_TIME_US 40000
`define QRS_HBE_TIME_US 150000
`define QRS_BE_TIME_US 250000
`endif

// ---- verilog/qrs_sync.v ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module qrs_sync #(
  parameter W = 6
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_q;

  // first stage feeds only the second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{1'b1}};
      q <= {W{1'b1}};
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // qrs_sync
`default_nettype wire

// ---- verilog/qrs_tmr.v ----
// down counter that times the self-timed erase cycle
`timescale 1ns/1ps
`default_nettype none
module qrs_tmr #(
  parameter W = 32
) (
  input wire clk,
  input wire rst_n,
  input wire load,
  input wire [W-1:0] count,
  output reg done
);
  reg [W-1:0] cnt_q;
  reg run_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= {W{1'b0}};
      run_q <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        cnt_q <= count;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
          run_q <= 1'b0;
          done <= 1'b1;
        end
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // qrs_tmr
`default_nettype wire

// ---- sim/qrs_top_props.sv ----
// assertion checker on the sequencer top ports
`timescale 1ns/1ps
`default_nettype none
module qrs_top_props (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic CS_B,
  input wire logic [3:0] IO_LINE_OE,
  input wire logic [23:0] MEM_ADDR,
  input wire logic ERASE_GO,
  input wire logic [23:0] ERASE_BASE,
  input wire logic [1:0] ERASE_SIZE,
  input wire logic WRITE_IN_PROGRESS,
  input wire logic WRITE_ENABLE_LATCH
);
  logic [23:0] span;
  assign span = (ERASE_SIZE == 2'h3) ? 24'h00FFFF : (ERASE_SIZE == 2'h2) ? 24'h007FFF :
    (ERASE_SIZE == 2'h1) ? 24'h000FFF : 24'h0000FF;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  a_oe_all_none: assert property (IO_LINE_OE == 4'h0 || IO_LINE_OE == 4'hF)
    else $error("io enables split");
  a_oe_cs_high: assert property (CS_B [*6] |-> IO_LINE_OE == 4'h0)
    else $error("lines driven while deselected");
  a_go_one_cycle: assert property (ERASE_GO |=> !ERASE_GO)
    else $error("erase pulse too long");
  a_go_with_wip: assert property (ERASE_GO |-> ##[0:1] WRITE_IN_PROGRESS)
    else $error("erase without busy");
  a_go_needs_wel: assert property (ERASE_GO |-> WRITE_ENABLE_LATCH)
    else $error("erase without latch");
  a_wip_after_cs: assert property ($rose(WRITE_IN_PROGRESS) |-> CS_B)
    else $error("cycle started while selected");
  a_wel_end_clear: assert property ($fell(WRITE_IN_PROGRESS) |-> !WRITE_ENABLE_LATCH)
    else $error("latch kept after cycle");
  a_wel_rise_idle: assert property ($rose(WRITE_ENABLE_LATCH) |-> CS_B && !WRITE_IN_PROGRESS)
    else $error("latch set at wrong time");
  a_base_aligned: assert property (ERASE_GO |-> (ERASE_BASE & span) == 24'h000000)
    else $error("erase base not aligned");
  a_base_hold: assert property ($changed(ERASE_BASE) |-> $rose(WRITE_IN_PROGRESS))
    else $error("erase base moved");
  a_addr_in_array: assert property (MEM_ADDR <= 24'h03FFFF)
    else $error("read address beyond array");
endmodule // qrs_top_props
bind qrs_top qrs_top_props props_u (.MCLK(MCLK), .RST_B(RST_B), .CS_B(CS_B),
  .IO_LINE_OE(IO_LINE_OE), .MEM_ADDR(MEM_ADDR), .ERASE_GO(ERASE_GO),
  .ERASE_BASE(ERASE_BASE), .ERASE_SIZE(ERASE_SIZE), .WRITE_IN_PROGRESS(WRITE_IN_PROGRESS),
  .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH));
`default_nettype wire

// ---- sim/qrs_host.sv ----
// host flash controller model driving the serial link
`timescale 1ns/1ps
`default_nettype none
module qrs_host (
  output logic cs_b,
  output logic sclk,
  output logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe
);
  logic drv_en = 1'b0;
  logic [3:0] drv_q = 4'h0;
  logic [3:0] junk = 4'h5;
  // a released line toggles so stale data never passes for a match
  assign io_in = (io_oe & io_out) | (~io_oe & (drv_en ? drv_q : junk));
  initial begin
    cs_b = 1'b1;
    sclk = 1'b0;
  end
  always @(posedge sclk)
    junk <= ~junk;
  // clock stands low between frames; w lines per clock, 0 listens
  task automatic clocks(input logic [31:0] v, input int n, input int w, output logic [31:0] r);
    r = 32'h0;
    for (int i = n - 1; i >= 0; i--) begin
      drv_en = (w != 0);
      drv_q = (w == 4) ? v[4*i +: 4] : {junk[3:1], v[i]};
      #32 sclk = 1'b1;
      r = {r[27:0], io_in};
      #32 sclk = 1'b0;
    end
  endtask
  task automatic sel(input logic on);
    #32 cs_b = ~on;
    drv_en = 1'b0;
    #64;
  endtask
endmodule // qrs_host
`default_nettype wire

// ---- sim/qrs_top_tb.sv ----
// self-checking bench of the quad read and erase sequencer
`timescale 1ns/1ps
`default_nettype none
`include "qrs_defs.vh"
module qrs_top_tb;
  logic mclk, rst_b, qe, ext_busy, cs_b, sclk, erase_go, write_in_progress, write_enable_latch, cra;
  logic [4:0] bp;
  logic [3:0] io_in, io_out, io_oe;
  logic [23:0] mem_addr, erase_base;
  logic [1:0] erase_size;
  logic [31:0] d, seed;
  logic [7:0] ops [4] = '{`QRS_OP_PE, `QRS_OP_SE, `QRS_OP_HBE, `QRS_OP_BE};
  logic [23:0] spans [4] = '{`QRS_SPAN_PAGE, `QRS_SPAN_SECT, `QRS_SPAN_HBLK, `QRS_SPAN_BLK};
  int error_cnt = 0;
  int num_checks = 0;
  int go_cnt = 0;
  int oe_cnt = 0;
  int n0, a;
  function automatic logic [7:0] mv(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ {6'h00, x[17:16]};
  endfunction
  qrs_host host_u (.cs_b(cs_b), .sclk(sclk), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
  qrs_top #(.PE_CYC(32'h64), .SE_CYC(32'h3E8), .HBE_CYC(32'h64), .BE_CYC(32'h64)) dut_u (
    .MCLK(mclk), .RST_B(rst_b), .CS_B(cs_b), .SCLK(sclk), .IO_LINE_IN(io_in),
    .IO_LINE_OUT(io_out), .IO_LINE_OE(io_oe), .QUAD_ENABLE_BIT(qe), .BLOCK_PROTECT_BITS(bp),
    .EXT_BUSY(ext_busy), .MEM_ADDR(mem_addr), .MEM_RDATA(mv(mem_addr)), .ERASE_GO(erase_go),
    .ERASE_BASE(erase_base), .ERASE_SIZE(erase_size), .WRITE_IN_PROGRESS(write_in_progress),
    .WRITE_ENABLE_LATCH(write_enable_latch), .CONTINUOUS_READ_ACTIVE(cra));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    go_cnt <= go_cnt + int'(erase_go === 1'b1);
    oe_cnt <= oe_cnt + int'(io_oe !== 4'h0);
  end
  // four bytes from x, wrapping in a wl-byte section or at the array top
  function automatic logic [31:0] exp4(input int x, input int wl);
    logic [31:0] e;
    e = 32'h0;
    for (int k = 0; k < 4; k++) begin
      e = {e[23:0], mv(x[23:0])};
      x = (wl == 0) ? (x + 1) % 32'h40000 : (x & ~(wl - 1)) | ((x + 1) & (wl - 1));
    end
    return e;
  endfunction
  // 1 when the protect bits cover any byte of lo..hi
  function automatic int shut(input logic [4:0] b, input int lo, input int hi);
    int len;
    len = (b[4] ? 32'h1000 : 32'h10000) << b[2:0];
    if (b[2:0] == 3'h0)
      return 0;
    if (len >= 32'h40000)
      return 1;
    return b[3] ? int'(lo < len) : int'(hi >= 32'h40000 - len);
  endfunction
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic setin(input logic q, input logic [4:0] b, input logic x);
    @(negedge mclk);
    qe = q;
    bp = b;
    ext_busy = x;
  endtask
  // opcode 00 stands for a frame without opcode
  task automatic rd(input logic [7:0] op, input logic quad, input logic [7:0] m, input int x);
    @(negedge mclk);
    host_u.sel(1'b1);
    if (op != 8'h00)
      host_u.clocks({24'h0, op}, 8, 1, d);
    if (quad) begin
      host_u.clocks(x, 6, 4, d);
      host_u.clocks({24'h0, m}, 2, 4, d);
      host_u.clocks(32'h0, 4, 0, d);
    end else begin
      host_u.clocks(x, 24, 1, d);
      host_u.clocks(32'h0, 8, 1, d);
    end
    host_u.clocks(32'h0, 8, 0, d);
    host_u.sel(1'b0);
  endtask
  task automatic ers(input logic [7:0] op, input int x, input int nb);
    @(negedge mclk);
    host_u.sel(1'b1);
    host_u.clocks({24'h0, op}, 8, 1, d);
    if (nb > 0)
      host_u.clocks(x, nb, 1, d);
    host_u.sel(1'b0);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 3000 && write_in_progress !== 1'b0; i++)
      @(negedge mclk);
    chk("idle", 32'h0, 32'(write_in_progress));
    if (write_in_progress !== 1'b0)
      summarize();
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    seed = 32'hA5485664;
    rst_b = 1'b0;
    qe = 1'b1;
    ext_busy = 1'b0;
    bp = 5'h00;
    repeat (20) @(negedge mclk);
    rst_b = 1'b1;
    repeat (10) @(negedge mclk);
    rd(`QRS_OP_QOUT, 1'b0, 8'h00, 32'h3FFFE);
    chk("qout", exp4(32'h3FFFE, 0), d);
    setin(1'b0, 5'($random(seed)), 1'($random(seed)));
    n0 = oe_cnt;
    rd(`QRS_OP_QOUT, 1'b0, 8'h00, 0);
    rd(`QRS_OP_QIO, 1'b1, 8'h00, 0);
    chk("qe off", n0, oe_cnt);
    setin(1'b1, 5'($random(seed)), 1'b1);
    rd(`QRS_OP_QIO, 1'b1, 8'h00, 0);
    chk("busy", n0, oe_cnt);
    setin(1'b1, 5'($random(seed)), 1'b0);
    a = $random(seed) & 32'h3FFF0;
    rd(`QRS_OP_QIO, 1'b1, 8'h20, a);
    chk("qio", exp4(a, 0), d);
    chk("armed", 32'h1, 32'(cra));
    rd(8'h00, 1'b1, 8'hF0, a + 5);
    chk("no opcode", exp4(a + 5, 0), d);
    chk("disarmed", 32'h0, 32'(cra));
    rd(`QRS_OP_QIO, 1'b1, 8'h20, a);
    @(negedge mclk);
    host_u.sel(1'b1);
    host_u.clocks(32'hFFFFFFFF, 8, 4, d);
    host_u.sel(1'b0);
    chk("mode reset", 32'h0, 32'(cra));
    rd(`QRS_OP_QOUT, 1'b0, 8'h00, a);
    chk("opcode again", exp4(a, 0), d);
    for (int n = 0; n < 4; n++) begin
      ers(`QRS_OP_WRAP, n << 5, 32);
      a = ($random(seed) & 32'h3FF00) | ((8 << n) - 2);
      rd(`QRS_OP_QIO, 1'b1, 8'h00, a);
      chk("wrap", exp4(a, 8 << n), d);
    end
    ers(`QRS_OP_WRAP, 32'h10, 32);
    rd(`QRS_OP_QIO, 1'b1, 8'h00, 32'hFE);
    chk("unwrapped", exp4(32'hFE, 0), d);
    for (int k = 0; k < 4; k++) begin
      a = $random(seed) & 32'h3FFFF;
      setin(1'b1, 5'($random(seed)), 1'b0);
      ers(`QRS_OP_WRITE_ENABLE_COMMAND, 0, 0);
      chk("wel", 32'h1, 32'(write_enable_latch));
      n0 = go_cnt;
      ers(ops[k], a, 24);
      chk("wip", 32'h1, 32'(write_in_progress));
      chk("go", n0 + 1 - shut(bp, a & ~spans[k], a | spans[k]), go_cnt);
      chk("base", a & ~spans[k], erase_base);
      chk("size", k, 32'(erase_size));
      wait_idle();
      chk("wel end", 32'h0, 32'(write_enable_latch));
    end
    n0 = go_cnt;
    ers(`QRS_OP_SE, a, 24);
    chk("no latch", 32'h0, 32'(write_in_progress));
    ers(`QRS_OP_WRITE_ENABLE_COMMAND, 0, 0);
    ers(`QRS_OP_SE, a, 25);
    chk("late cs", 32'h0, 32'(write_in_progress));
    setin(1'b1, 5'h01, 1'b0);
    ers(`QRS_OP_HBE, 32'h3F123, 24);
    chk("prot wip", 32'h1, 32'(write_in_progress));
    wait_idle();
    chk("prot go", n0, go_cnt);
    chk("prot wel", 32'h0, 32'(write_enable_latch));
    setin(1'b1, 5'($random(seed)), 1'b0);
    ers(`QRS_OP_WRITE_ENABLE_COMMAND, 0, 0);
    ers(`QRS_OP_SE, a, 24);
    n0 = oe_cnt;
    rd(`QRS_OP_QOUT, 1'b0, 8'h00, a);
    chk("read in cycle", n0, oe_cnt);
    chk("cycle kept", 32'h1, 32'(write_in_progress));
    wait_idle();
    summarize();
  end
endmodule // qrs_top_tb
`default_nettype wire
